// *** hw/tfr_pkg.sv ***
// Overview of operation
// - A 64-pixel 12-bit frame leaves in 96 reads: 3 per pair, 4 pairs, 8 rows.
// - Frame delivery starts at the middle rows of the vertical axis, moving outward.
// - Row reads one to four give rows 3, 4, 2, 5; reads seven and eight give 0, 7.
// - Within a row the pairs go out as columns 0-1, 2-3, 4-5, 6-7.
// - An even and an odd 12-bit pixel share one 3-byte group.
// - Pair bytes: even[11:4], then even[3:0] with odd[3:0], then odd[11:4].
// - Saturated pixels read 0x7ff and set the saturation flag registers.
// - ADC overflow reads 0x7fe and sets the overflow flag registers.
// - ADC underflow reads 0x800 and sets the underflow flag registers.
// - Valid pixels stay within 0x801 to 0x7fd so flag codes never collide.
// - Embedded flag codes are on after power-up; bit 6 of format control disables them.
// - Until its program has loaded the device answers busy; then NOPs echo zero.
// - The selected page holds until another page-select word arrives.
// - Data ready shows on a pin and a status bit once readout data stands.
package tfr_pkg;
  localparam logic [6:0]  PAGE_PIX      = 7'h02;
  localparam logic [6:0]  PAGE_CFG      = 7'h04;
  localparam logic [4:0]  ADDR_PIXPORT  = 5'h0c;
  localparam logic [4:0]  ADDR_SAT_A    = 5'h0d;
  localparam logic [4:0]  ADDR_SAT_B    = 5'h0e;
  localparam logic [4:0]  ADDR_OVF_A    = 5'h10;
  localparam logic [4:0]  ADDR_OVF_B    = 5'h11;
  localparam logic [4:0]  ADDR_UDF_A    = 5'h12;
  localparam logic [4:0]  ADDR_UDF_B    = 5'h13;
  localparam logic [4:0]  ADDR_STATUS   = 5'h15;
  localparam logic [5:0]  ADDR_FORMAT   = 6'h15;
  localparam int          FMT_RAW_BIT   = 6;
  localparam int          STAT_RDY_BIT  = 3;
  localparam logic [7:0]  FORMAT_RESET  = 8'h00;
  localparam logic [6:0]  PAGE_RESET    = 7'h00;
  localparam logic [15:0] BUSY_WORD     = 16'hffff;
  localparam logic [11:0] CODE_SAT      = 12'h7ff;
  localparam logic [11:0] CODE_OVF      = 12'h7fe;
  localparam logic [11:0] CODE_UDF      = 12'h800;
  localparam logic [11:0] VALID_MAX     = 12'h7fd;
  localparam logic [11:0] VALID_MIN     = 12'h801;
  localparam logic [1:0]  KIND_OK       = 2'h0;
  localparam logic [1:0]  KIND_SAT      = 2'h1;
  localparam logic [1:0]  KIND_OVF      = 2'h2;
  localparam logic [1:0]  KIND_UDF      = 2'h3;
  localparam logic [1:0]  LAST_BYTE     = 2'h2;
  localparam logic [1:0]  LAST_PAIR     = 2'h3;
  localparam logic [2:0]  LAST_ROW      = 3'h7;
  localparam logic [3:0]  LAST_BIT      = 4'hf;
  // Entry i is the sensor row sent on the i-th row read
  localparam logic [7:0][2:0] ROW_MAP   = {3'h7, 3'h0, 3'h6, 3'h1, 3'h5, 3'h2, 3'h4, 3'h3};
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          BOOT_TIME_NS  = 10000;
  localparam int          BOOT_CYCLES   = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    TFR_BOOT = 2'b01,
    TFR_IDLE = 2'b10
  } tfr_mode_t;
endpackage

// *** hw/tfr_spi_if.sv ***
`timescale 1ns/1ps
interface tfr_spi_if;
  logic [15:0] rx_word;
  logic        rx_valid;
  logic [15:0] tx_word;
  modport shifter (output rx_word, output rx_valid, input tx_word);
  modport core    (input rx_word, input rx_valid, output tx_word);
endinterface

// *** hw/tfr_pix_coder.sv ***
`timescale 1ns/1ps
module tfr_pix_coder (
  // Pixel in
  input  wire logic [11:0] i_raw,
  input  wire logic [1:0]  i_kind,
  input  wire logic        i_embed,
  // Coded pixel out
  output logic      [11:0] o_code
);
  always_comb begin
    o_code = i_raw;
    if (i_embed) begin
      if (i_kind == tfr_pkg::KIND_SAT) begin
        o_code = tfr_pkg::CODE_SAT;
      end else if (i_kind == tfr_pkg::KIND_OVF) begin
        o_code = tfr_pkg::CODE_OVF;
      end else if (i_kind == tfr_pkg::KIND_UDF) begin
        o_code = tfr_pkg::CODE_UDF;
      end else if (i_raw == tfr_pkg::CODE_SAT || i_raw == tfr_pkg::CODE_OVF) begin
        o_code = tfr_pkg::VALID_MAX;
      end else if (i_raw == tfr_pkg::CODE_UDF) begin
        o_code = tfr_pkg::VALID_MIN;
      end
    end
  end
endmodule

// *** hw/tfr_spi_shift.sv ***
`timescale 1ns/1ps
module tfr_spi_shift (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Serial pins
  input  wire logic i_spi_sck,
  input  wire logic i_spi_cs_n,
  input  wire logic i_spi_mosi,
  output logic      o_spi_miso,
  output logic      o_spi_miso_oe,
  // Word side
  tfr_spi_if.shifter bus
);
  typedef struct packed {
    logic [1:0]  sck_s;
    logic [1:0]  cs_s;
    logic [1:0]  mosi_s;
    logic        sck_d;
    logic        cs_d;
    logic [3:0]  cnt;
    logic [15:0] rx_sh;
    logic [15:0] tx_sh;
    logic [15:0] rx_word;
    logic        rx_valid;
  } tfr_shift_t;

  tfr_shift_t s;
  tfr_shift_t next_s;

  always_comb begin
    next_s = s;
    next_s.sck_s = {s.sck_s[0], i_spi_sck};
    next_s.cs_s = {s.cs_s[0], i_spi_cs_n};
    next_s.mosi_s = {s.mosi_s[0], i_spi_mosi};
    next_s.sck_d = s.sck_s[1];
    next_s.cs_d = s.cs_s[1];
    next_s.rx_valid = 1'b0;
    if (s.cs_s[1]) begin
      next_s.cnt = 4'h0;
    end else if (s.cs_d) begin
      // Mode 0: first bit must stand before the first rising edge
      next_s.cnt = 4'h0;
      next_s.tx_sh = bus.tx_word;
    end else if (s.sck_s[1] && !s.sck_d) begin
      next_s.rx_sh = {s.rx_sh[14:0], s.mosi_s[1]};
      next_s.cnt = s.cnt + 4'h1;
      if (s.cnt == tfr_pkg::LAST_BIT) begin
        next_s.rx_word = {s.rx_sh[14:0], s.mosi_s[1]};
        next_s.rx_valid = 1'b1;
      end
    end else if (!s.sck_s[1] && s.sck_d) begin
      // Reload at the word boundary so back-to-back words need no gap
      if (s.cnt == 4'h0) begin
        next_s.tx_sh = bus.tx_word;
      end else begin
        next_s.tx_sh = {s.tx_sh[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{sck_s: 2'h0, cs_s: 2'h3, mosi_s: 2'h0, sck_d: 1'b0, cs_d: 1'b1,
             cnt: 4'h0, rx_sh: 16'h0000, tx_sh: 16'h0000, rx_word: 16'h0000,
             rx_valid: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign o_spi_miso = s.tx_sh[15];
  assign o_spi_miso_oe = ~s.cs_s[1];
  assign bus.rx_word = s.rx_word;
  assign bus.rx_valid = s.rx_valid;
endmodule

// *** hw/tfr_frame_port.sv ***
`timescale 1ns/1ps
module tfr_frame_port #(
  parameter int BOOT_CYCLES = tfr_pkg::BOOT_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Serial target pins
  input  wire logic        i_spi_sck,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_mosi,
  output logic             o_spi_miso,
  output logic             o_spi_miso_oe,
  // Acquisition side
  input  wire logic        i_frame_start,
  input  wire logic        i_pix_wr,
  input  wire logic [5:0]  i_pix_addr,
  input  wire logic [11:0] i_pix_data,
  input  wire logic        i_pix_sat,
  input  wire logic        i_pix_ovf,
  input  wire logic        i_pix_udf,
  input  wire logic        i_frame_done,
  // Status
  output logic             o_data_ready,
  output logic             o_idle
);
  localparam int BCW = $clog2(BOOT_CYCLES + 1);

  typedef struct packed {
    tfr_pkg::tfr_mode_t mode;
    logic [BCW-1:0]     boot_cnt;
    logic [6:0]         page;
    logic [7:0]         fmt;
    logic [15:0]        resp;
    logic [1:0]         byte_i;
    logic [1:0]         pair_i;
    logic [2:0]         row_i;
    logic               frame_rdy;
    logic [15:0]        sat;
    logic [15:0]        ovf;
    logic [15:0]        udf;
    logic [63:0][13:0]  mem;
  } tfr_core_t;

  tfr_core_t s;
  tfr_core_t next_s;

  tfr_spi_if bus ();

  tfr_spi_shift u_shift (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_spi_sck     (i_spi_sck),
    .i_spi_cs_n    (i_spi_cs_n),
    .i_spi_mosi    (i_spi_mosi),
    .o_spi_miso    (o_spi_miso),
    .o_spi_miso_oe (o_spi_miso_oe),
    .bus           (bus.shifter)
  );

  logic [2:0]  cur_row;
  logic [5:0]  even_idx;
  logic [5:0]  odd_idx;
  logic [13:0] even_ent;
  logic [13:0] odd_ent;
  logic [11:0] even_code;
  logic [11:0] odd_code;
  logic        embed;
  logic [7:0]  pix_byte;
  logic [1:0]  wr_kind;
  logic [15:0] wr_bit;

  // Pair position from the read counters
  always_comb begin
    cur_row = tfr_pkg::ROW_MAP[s.row_i];
    even_idx = {cur_row, s.pair_i, 1'b0};
    odd_idx = {cur_row, s.pair_i, 1'b1};
    even_ent = s.mem[even_idx];
    odd_ent = s.mem[odd_idx];
    embed = ~s.fmt[tfr_pkg::FMT_RAW_BIT];
  end

  tfr_pix_coder u_even (
    .i_raw   (even_ent[11:0]),
    .i_kind  (even_ent[13:12]),
    .i_embed (embed),
    .o_code  (even_code)
  );

  tfr_pix_coder u_odd (
    .i_raw   (odd_ent[11:0]),
    .i_kind  (odd_ent[13:12]),
    .i_embed (embed),
    .o_code  (odd_code)
  );

  // Byte of the current pair group
  always_comb begin
    if (s.byte_i == 2'h0) begin
      pix_byte = even_code[11:4];
    end else if (s.byte_i == 2'h1) begin
      pix_byte = {even_code[3:0], odd_code[3:0]};
    end else begin
      pix_byte = odd_code[11:4];
    end
  end

  // Kind of an incoming pixel; saturation outranks the converter limits
  always_comb begin
    if (i_pix_sat) begin
      wr_kind = tfr_pkg::KIND_SAT;
    end else if (i_pix_ovf) begin
      wr_kind = tfr_pkg::KIND_OVF;
    end else if (i_pix_udf) begin
      wr_kind = tfr_pkg::KIND_UDF;
    end else begin
      wr_kind = tfr_pkg::KIND_OK;
    end
    wr_bit = 16'h0001 << i_pix_addr[5:2];
  end

  function automatic logic [7:0] read_reg(input tfr_core_t st, input logic [4:0] addr,
                                          input logic [7:0] pix);
    logic [7:0] v;
    v = 8'h00;
    if (st.page == tfr_pkg::PAGE_PIX) begin
      if (addr == tfr_pkg::ADDR_PIXPORT) begin
        v = pix;
      end else if (addr == tfr_pkg::ADDR_SAT_A) begin
        v = st.sat[7:0];
      end else if (addr == tfr_pkg::ADDR_SAT_B) begin
        v = st.sat[15:8];
      end else if (addr == tfr_pkg::ADDR_OVF_A) begin
        v = st.ovf[7:0];
      end else if (addr == tfr_pkg::ADDR_OVF_B) begin
        v = st.ovf[15:8];
      end else if (addr == tfr_pkg::ADDR_UDF_A) begin
        v = st.udf[7:0];
      end else if (addr == tfr_pkg::ADDR_UDF_B) begin
        v = st.udf[15:8];
      end else if (addr == tfr_pkg::ADDR_STATUS) begin
        v[tfr_pkg::STAT_RDY_BIT] = st.frame_rdy;
      end
    end else if (st.page == tfr_pkg::PAGE_CFG) begin
      if (addr == tfr_pkg::ADDR_FORMAT[4:0]) begin
        v = st.fmt;
      end
    end
    return v;
  endfunction

  logic [15:0] w;

  always_comb begin
    next_s = s;
    w = bus.rx_word;
    if (s.mode == tfr_pkg::TFR_BOOT) begin
      // Sequencer program still loading; words are not acted on
      next_s.resp = tfr_pkg::BUSY_WORD;
      if (s.boot_cnt == BCW'(BOOT_CYCLES - 1)) begin
        next_s.mode = tfr_pkg::TFR_IDLE;
        next_s.resp = 16'h0000;
      end else begin
        next_s.boot_cnt = s.boot_cnt + BCW'(1);
      end
    end else if (bus.rx_valid) begin
      next_s.resp = w;
      if (w[15]) begin
        next_s.page = w[14:8];
      end else if (w[15:14] == 2'b01) begin
        // Only the format register is writable here; adjust writes are absorbed
        if (s.page == tfr_pkg::PAGE_CFG && w[13:8] == tfr_pkg::ADDR_FORMAT) begin
          next_s.fmt = w[7:0];
        end
      end else if (w[15:13] == 3'b001) begin
        next_s.resp = {w[15:8], read_reg(s, w[12:8], pix_byte)};
        if (s.page == tfr_pkg::PAGE_PIX && w[12:8] == tfr_pkg::ADDR_PIXPORT) begin
          // Every data port read advances the transfer order
          if (s.byte_i == tfr_pkg::LAST_BYTE) begin
            next_s.byte_i = 2'h0;
            next_s.pair_i = s.pair_i + 2'h1;
            if (s.pair_i == tfr_pkg::LAST_PAIR) begin
              next_s.row_i = s.row_i + 3'h1;
              if (s.row_i == tfr_pkg::LAST_ROW) begin
                next_s.frame_rdy = 1'b0;
              end
            end
          end else begin
            next_s.byte_i = s.byte_i + 2'h1;
          end
        end
      end
    end
    // Flags clear at frame start; a same-cycle pixel event still sets
    if (i_frame_start) begin
      next_s.sat = 16'h0000;
      next_s.ovf = 16'h0000;
      next_s.udf = 16'h0000;
    end
    if (i_pix_wr) begin
      next_s.mem[i_pix_addr] = {wr_kind, i_pix_data};
      if (wr_kind == tfr_pkg::KIND_SAT) begin
        next_s.sat = next_s.sat | wr_bit;
      end else if (wr_kind == tfr_pkg::KIND_OVF) begin
        next_s.ovf = next_s.ovf | wr_bit;
      end else if (wr_kind == tfr_pkg::KIND_UDF) begin
        next_s.udf = next_s.udf | wr_bit;
      end
    end
    // A new frame restarts the order even mid-readout
    if (i_frame_done) begin
      next_s.frame_rdy = 1'b1;
      next_s.byte_i = 2'h0;
      next_s.pair_i = 2'h0;
      next_s.row_i = 3'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{mode: tfr_pkg::TFR_BOOT, boot_cnt: '0, page: tfr_pkg::PAGE_RESET,
             fmt: tfr_pkg::FORMAT_RESET, resp: tfr_pkg::BUSY_WORD, byte_i: 2'h0,
             pair_i: 2'h0, row_i: 3'h0, frame_rdy: 1'b0, sat: 16'h0000,
             ovf: 16'h0000, udf: 16'h0000, mem: '0};
    end else begin
      s <= next_s;
    end
  end

  assign bus.tx_word = s.resp;
  assign o_data_ready = s.frame_rdy;
  assign o_idle = (s.mode == tfr_pkg::TFR_IDLE);
endmodule

// *** verification/tfr_props.sv ***
`timescale 1ns/1ps
module tfr_props #(
  parameter int BOOT_CYCLES = 20
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Serial pins
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic o_spi_miso,
  input wire logic o_spi_miso_oe,
  // Frame and status
  input wire logic i_frame_done,
  input wire logic o_data_ready,
  input wire logic o_idle
);
  int unsigned cnt;
  // Saturates so a long run cannot wrap
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 0;
    end else if (cnt < BOOT_CYCLES + 8) begin
      cnt <= cnt + 1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_cs_on;
    !i_spi_cs_n [*4];
  endsequence
  sequence s_cs_off;
    i_spi_cs_n [*4];
  endsequence
  sequence s_busy_frame;
    (!i_spi_cs_n && !o_idle) [*8];
  endsequence
  sequence s_done_seen;
    $past(i_frame_done) || $past(i_frame_done, 2);
  endsequence
  a_boot_busy: assert property (cnt + 2 < BOOT_CYCLES |-> !o_idle)
    else $error("idle too early");
  a_boot_done: assert property (cnt > BOOT_CYCLES + 2 |-> o_idle)
    else $error("idle too late");
  a_idle_holds: assert property (o_idle |=> o_idle)
    else $error("idle dropped");
  a_busy_word: assert property (s_busy_frame |-> o_spi_miso)
    else $error("busy answer not ones");
  a_oe_on: assert property (s_cs_on |-> o_spi_miso_oe)
    else $error("miso not driven");
  a_oe_off: assert property (s_cs_off |-> !o_spi_miso_oe)
    else $error("miso driven unselected");
  a_miso_hold: assert property (i_spi_sck [*5] |-> $stable(o_spi_miso))
    else $error("miso moved while sck high");
  a_ready_set: assert property (i_frame_done |-> ##[1:2] o_data_ready)
    else $error("ready not set");
  a_ready_cause: assert property ($rose(o_data_ready) |-> s_done_seen)
    else $error("ready without frame");
  a_ready_clear: assert property ($fell(o_data_ready) |-> !i_spi_cs_n)
    else $error("ready fell outside read");
endmodule

// *** verification/tfr_host.sv ***
`timescale 1ns/1ps
module tfr_host (
  // Serial pins
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_mosi
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Mode 0, MSB first; one word per select, clock still between frames
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = w[i];
      #62.5 o_sck = 1'b1;
      r[i] = i_miso;
      #62.5 o_sck = 1'b0;
    end
    #62.5 o_cs_n = 1'b1;
    // Released line must not show a stale bit
    o_mosi = ~o_mosi;
    #250;
  endtask
endmodule

// *** verification/tfr_frame_port_bench.sv ***
`timescale 1ns/1ps
module tfr_frame_port_bench;
  // Arbitrary older wafer, so both adjust groups go out
  localparam int wafer_identifier = 12;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        start = 1'b0;
  logic        done = 1'b0;
  logic        wr = 1'b0;
  logic [2:0]  flags = 3'h0;
  logic [5:0]  addr = 6'h00;
  logic [11:0] data = 12'h000;
  wire         sck, cs_n, mosi, miso, ready, idle;
  logic [31:0] seed = 32'h0000c707;
  logic [15:0] pexp, r, f;
  logic [11:0] pix [64];
  logic [1:0]  kind [64];
  int          error_cnt = 0;
  int          total_checks = 0;
  int          rows [8] = '{3, 4, 2, 5, 1, 6, 0, 7};
  logic [7:0]  fa [3] = '{8'h2d, 8'h30, 8'h32};
  logic [15:0] adj [10] = '{16'h8100, 16'h5a00, 16'h8500, 16'h4b00, 16'h8400,
                            16'h481f, 16'h8500, 16'h4e01, 16'h8600, 16'h5162};

  always #2 i_clk = ~i_clk;

  tfr_frame_port #(.BOOT_CYCLES(1000)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(), .i_frame_start(start),
    .i_pix_wr(wr), .i_pix_addr(addr), .i_pix_data(data), .i_pix_sat(flags[0]),
    .i_pix_ovf(flags[1]), .i_pix_udf(flags[2]), .i_frame_done(done),
    .o_data_ready(ready), .o_idle(idle));
  tfr_host u_host (.i_miso(miso), .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] code(int i, logic emb);
    if (!emb) return pix[i];
    case (kind[i])
      2'h1: return 12'h7ff;
      2'h2: return 12'h7fe;
      2'h3: return 12'h800;
      default: ;
    endcase
    // Real samples never alias a flag code
    if (pix[i] == 12'h7fe || pix[i] == 12'h7ff) return 12'h7fd;
    if (pix[i] == 12'h800) return 12'h801;
    return pix[i];
  endfunction

  function automatic logic [7:0] pbyte(int n, logic emb);
    logic [11:0] e, o;
    e = code(rows[n / 12] * 8 + (n % 12) / 3 * 2, emb);
    o = code(rows[n / 12] * 8 + (n % 12) / 3 * 2 + 1, emb);
    case (n % 3)
      0: return e[11:4];
      1: return {e[3:0], o[3:0]};
      default: return o[11:4];
    endcase
  endfunction

  function automatic logic [15:0] flg(logic [1:0] k);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 64; i++) if (kind[i] == k) v[i / 4] = 1'b1;
    return v;
  endfunction

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Answer to a word arrives during the next one
  task automatic sx(logic [15:0] w, logic [7:0] lo);
    u_host.xfer(w, r);
    chk(r, pexp);
    pexp = {w[15:8], lo};
  endtask

  task automatic pulse_done();
    @(negedge i_clk);
    done = 1'b1;
    @(negedge i_clk);
    done = 1'b0;
    @(negedge i_clk);
  endtask

  task automatic load();
    @(negedge i_clk);
    start = 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(negedge i_clk);
      start = 1'b0;
      pix[i] = 12'(rnd());
      if (i % 20 == 9) pix[i] = 12'h7fe + 12'(i / 20);
      kind[i] = (i % 11 == 3) ? 2'(i % 3 + 1) : 2'h0;
      addr = 6'(i);
      data = pix[i];
      flags = {kind[i] == 2'h3, kind[i] == 2'h2, kind[i] == 2'h1};
      wr = 1'b1;
    end
    @(negedge i_clk);
    wr = 1'b0;
    pulse_done();
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    $display("Error at %0t: timeout", $time);
    results();
  end

  initial begin
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk({15'h0000, idle}, 16'h0000);
    pexp = 16'hffff;
    sx(16'h0000, 8'h00);
    for (int i = 0; i < 8 && r !== 16'h0000; i++) u_host.xfer(16'h0000, r);
    chk(r, 16'h0000);
    chk({15'h0000, idle}, 16'h0001);
    pexp = 16'h0000;
    $display("test boot done");
    for (int i = 0; i < (wafer_identifier < 13 ? 10 : 4); i++)
      sx(adj[i], adj[i][7:0]);
    $display("test adjust done");
    load();
    chk({15'h0000, ready}, 16'h0001);
    sx(16'h8200, 8'h00);
    sx(16'h3500, 8'h08);
    for (int n = 0; n < 96; n++)
      sx(16'h2c00, pbyte(n, 1'b1));
    sx(16'h3500, 8'h00);
    for (int k = 1; k < 4; k++) begin
      f = flg(2'(k));
      sx({fa[k - 1], 8'h00}, f[7:0]);
      sx({fa[k - 1] + 8'h01, 8'h00}, f[15:8]);
    end
    sx(16'h2100, 8'h00);
    sx(16'h0000, 8'h00);
    chk({15'h0000, ready}, 16'h0000);
    $display("test frame done");
    sx(16'h8400, 8'h00);
    sx(16'h5540, 8'h40);
    sx(16'h3500, 8'h40);
    pulse_done();
    sx(16'h8200, 8'h00);
    for (int n = 0; n < 12; n++)
      sx(16'h2c00, pbyte(n, 1'b0));
    sx(16'h0000, 8'h00);
    $display("test raw format done");
    results();
  end
endmodule

bind tfr_frame_port tfr_props #(.BOOT_CYCLES(BOOT_CYCLES)) u_props (.*);
